// File: hw/wdg_core.sv
// Purpose: Watchdog with keyed registers, overflow flag and overflow actions.
// Assumes: Classic Wishbone slave, one-cycle registered ack.
// Notes: Internal reset request is a level held until a system reset.
`timescale 1ns/10ps
module wdg_core
	import wdg_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Overflow actions
	output logic wd_reset_o,
	output logic wd_irq_o,
	output logic overflow_out_n_o
);
	// ==========================================================
	// Bus decode
	logic [3:0] action_r;
	logic [1:0] counter_clock_select_r;
	logic [3:0] high_preload_field_r;
	logic overflow_seen_flag_r;
	logic [15:0] count_r;
	logic [3:0] pin_cnt_r;
	logic tick;
	logic req;
	logic wr;
	logic wr_action;
	logic wr_clock;
	logic do_restart;
	logic overflow;
	logic guard_on;
	logic expired_r;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		return a == off;
	endfunction

	assign req = cyc_i && stb_i && !ack_o;
	// Writes commit at the edge where the master samples ack, so an abandoned
	// cycle changes nothing; they need the low lanes, or half a key could land
	assign wr = cyc_i && stb_i && ack_o && we_i && sel_i[1:0] == 2'b11;
	assign wr_action = wr && hit(adr_i, WDG_ADDR_ACTION) &&
		dat_i[15:4] == WDG_ACTION_KEY;
	assign wr_clock = wr && hit(adr_i, WDG_ADDR_CLOCK) &&
		dat_i[15:7] == WDG_CLOCK_KEY;
	assign do_restart = wr && hit(adr_i, WDG_ADDR_RESTART) &&
		dat_i[15:0] == WDG_RESTART_KEY;
	assign guard_on = action_r[WDG_BIT_GUARD_ON];
	// A parked counter must not fire again on every later tick
	assign overflow = guard_on && tick && count_r == 16'h0000 && !expired_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= req;
		end
	end

	// Unmapped offsets read zero and are still acknowledged
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h00000000;
		end else if (req && !we_i) begin
			case (adr_i)
				WDG_ADDR_ACTION: dat_o <= {28'h0000000, action_r};
				WDG_ADDR_CLOCK: dat_o <= {26'h0, high_preload_field_r,
					counter_clock_select_r};
				WDG_ADDR_STATUS: dat_o <= {31'h0, overflow_seen_flag_r};
				default: dat_o <= 32'h00000000;
			endcase
		end
	end

	// ==========================================================
	// Configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			action_r <= WDG_ACTION_RST;
		end else if (wr_action) begin
			action_r <= dat_i[3:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{high_preload_field_r, counter_clock_select_r} <= WDG_CLOCK_RST;
		end else if (wr_clock) begin
			high_preload_field_r <= dat_i[5:2];
			counter_clock_select_r <= dat_i[1:0];
		end
	end

	// ==========================================================
	// Counter
	wdg_divider u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(guard_on),
		.clear_i(do_restart),
		.sel_i(counter_clock_select_r),
		.tick_o(tick)
	);

	// Counter stops at zero after overflow until restarted
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_r <= {WDG_LOW_PRELOAD, 4'h0} | 16'hffff;
		end else if (do_restart) begin
			count_r <= {high_preload_field_r, WDG_LOW_PRELOAD};
		end else if (guard_on && tick && count_r != 16'h0000) begin
			count_r <= count_r - 16'h0001;
		end
	end

	// One overflow per restart; a restart reloads the counter, so it clears this
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			expired_r <= 1'b0;
		end else if (do_restart) begin
			expired_r <= 1'b0;
		end else if (overflow) begin
			expired_r <= 1'b1;
		end
	end

	// Overflow beats a restart written in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overflow_seen_flag_r <= 1'b0;
		end else if (overflow) begin
			overflow_seen_flag_r <= 1'b1;
		end else if (do_restart) begin
			overflow_seen_flag_r <= 1'b0;
		end
	end

	// ==========================================================
	// Overflow actions
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wd_reset_o <= 1'b0;
			wd_irq_o <= 1'b0;
		end else begin
			wd_reset_o <= wd_reset_o || (overflow && action_r[WDG_BIT_RESET_ON]);
			wd_irq_o <= overflow && action_r[WDG_BIT_IRQ_ON];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_cnt_r <= 4'h0;
			overflow_out_n_o <= 1'b1;
		end else if (overflow && action_r[WDG_BIT_PIN_ON]) begin
			pin_cnt_r <= WDG_PIN_LOAD - 4'h1;
			overflow_out_n_o <= 1'b0;
		end else if (pin_cnt_r != 4'h0) begin
			pin_cnt_r <= pin_cnt_r - 4'h1;
			overflow_out_n_o <= 1'b0;
		end else begin
			overflow_out_n_o <= 1'b1;
		end
	end

	// ==========================================================
	// Checks
	AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (rst_i)
		overflow |=> overflow_seen_flag_r)
		else $error("Overflow did not set the status flag");
	AST_FLAG_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
		(do_restart && !overflow) |=> !overflow_seen_flag_r)
		else $error("Restart did not clear the status flag");
	AST_DISABLE: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && adr_i == WDG_ADDR_ACTION && dat_i[15:0] == 16'h2340) |=> !guard_on)
		else $error("Disable write left the watchdog running");
	AST_RESET_OFF: assert property (@(posedge clk_i)
		rst_i |=> (!guard_on && !wd_reset_o && overflow_out_n_o))
		else $error("Watchdog not disabled after reset");
	AST_CLOCK_SETUP: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && adr_i == WDG_ADDR_CLOCK && dat_i[15:0] == 16'h373c) |=>
		(high_preload_field_r == 4'hf && counter_clock_select_r == 2'b00))
		else $error("Clock setup write not applied");
	AST_RELOAD: assert property (@(posedge clk_i) disable iff (rst_i)
		do_restart |=> count_r == {$past(high_preload_field_r), 12'hfff})
		else $error("Restart did not reload the counter");
	AST_ENABLE: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && adr_i == WDG_ADDR_ACTION && dat_i[15:0] == 16'h2345) |=>
		(guard_on && action_r[WDG_BIT_IRQ_ON] && !action_r[WDG_BIT_RESET_ON]))
		else $error("Enable write not applied");
	AST_PIN_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(overflow_out_n_o) |-> (!overflow_out_n_o [*8]) ##1 overflow_out_n_o)
		else $error("Overflow pin pulse is not 8 cycles");
	AST_IRQ_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
		wd_irq_o |=> !wd_irq_o)
		else $error("Interrupt pulse longer than one cycle");
	AST_BAD_KEY: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr && adr_i == WDG_ADDR_ACTION && dat_i[15:4] != 12'h234) |=>
		action_r == $past(action_r))
		else $error("Action register changed without its key");
	AST_IRQ_ONCE: assert property (@(posedge clk_i) disable iff (rst_i)
		wd_irq_o |=> (!wd_irq_o) [*8])
		else $error("Interrupt fired again without a restart");
	AST_QUIET_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
		!guard_on |=> !wd_irq_o)
		else $error("Disabled watchdog raised an interrupt");
endmodule

// File: hw/wdg_divider.sv
// Purpose: Master clock prescaler giving a one-cycle counter tick.
// Assumes: sel_i changes only while the watchdog is disabled and reprogrammed.
// Notes: Restart clears the prescaler so the first period is whole.
`timescale 1ns/10ps
module wdg_divider
	import wdg_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic run_i,
	input wire logic clear_i,
	input wire logic [1:0] sel_i,
	// Tick
	output logic tick_o
);
	logic [9:0] cnt_r;
	logic [9:0] last;

	always_comb begin
		case (sel_i)
			2'b00: last = WDG_DIV8;
			2'b01: last = WDG_DIV32;
			2'b10: last = WDG_DIV128;
			2'b11: last = WDG_DIV1024;
			default: last = WDG_DIV8;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i || !run_i) begin
			cnt_r <= 10'h000;
			tick_o <= 1'b0;
		end else if (cnt_r >= last) begin
			cnt_r <= 10'h000;
			tick_o <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 10'h001;
			tick_o <= 1'b0;
		end
	end

	AST_DIV_SPACING: assert property (@(posedge clk_i) disable iff (rst_i)
		(tick_o && sel_i == 2'b00 && run_i && !clear_i) |=>
		(!tick_o || clear_i || !run_i || sel_i != 2'b00) [*7])
		else $error("Divide-by-8 tick came too soon");
endmodule

// File: hw/wdg_pkg.sv
// Purpose: Constants for the watchdog overflow/enable block.
// Assumes: Classic Wishbone, 32-bit data, byte addresses.
// Notes: One clock; slower rates are enable pulses.
package wdg_pkg;
	// ==========================================================
	// Register map
	localparam logic [3:0] WDG_ADDR_ACTION = 4'h0;
	localparam logic [3:0] WDG_ADDR_CLOCK = 4'h4;
	localparam logic [3:0] WDG_ADDR_RESTART = 4'h8;
	localparam logic [3:0] WDG_ADDR_STATUS = 4'hc;
	// ==========================================================
	// Keys and fields
	localparam logic [11:0] WDG_ACTION_KEY = 12'h234;
	localparam logic [8:0] WDG_CLOCK_KEY = 9'h06e;
	localparam logic [15:0] WDG_RESTART_KEY = 16'hc071;
	localparam int WDG_BIT_GUARD_ON = 0;
	localparam int WDG_BIT_RESET_ON = 1;
	localparam int WDG_BIT_IRQ_ON = 2;
	localparam int WDG_BIT_PIN_ON = 3;
	localparam logic [3:0] WDG_ACTION_RST = 4'h0;
	localparam logic [5:0] WDG_CLOCK_RST = 6'h00;
	localparam logic [11:0] WDG_LOW_PRELOAD = 12'hfff;
	// ==========================================================
	// Timing
	localparam int WDG_PIN_CYCLES = 8;
	localparam logic [3:0] WDG_PIN_LOAD = 4'(WDG_PIN_CYCLES);
	localparam logic [9:0] WDG_DIV8 = 10'd7;
	localparam logic [9:0] WDG_DIV32 = 10'd31;
	localparam logic [9:0] WDG_DIV128 = 10'd127;
	localparam logic [9:0] WDG_DIV1024 = 10'd1023;
endpackage

// File: test/tb_top.sv
// Purpose: Self-checking bench for the watchdog core.
// Assumes: One-cycle registered ack; preload 0 gives a 0x1000*8 cycle timeout.
// Notes: Overflow test enables every action at once.
`timescale 1ns/10ps
module tb_top
	import wdg_pkg::*;
;
	// ==========================================================
	// Stimulus and design
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [3:0] adr_i = 4'h0;
	logic [3:0] sel_i = 4'hf;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic ack_o;
	logic wd_reset_o;
	logic wd_irq_o;
	logic overflow_out_n_o;
	logic [31:0] rd;
	int failures = 0;
	int comparisons = 0;
	int n;

	wdg_core uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.wd_reset_o(wd_reset_o), .wd_irq_o(wd_irq_o), .overflow_out_n_o(overflow_out_n_o));

	always #5 clk_i = ~clk_i;

	// ==========================================================
	// Shared tasks
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Holds the request until ack is sampled high, then releases it
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= we;
		adr_i <= adr;
		dat_i <= dat;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 50);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (k >= 50)
			chk("ack_wait", 32'h1, 32'h0);
	endtask

	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset_and_keys;
		wb(1'b0, WDG_ADDR_ACTION, 32'h0);
		chk("action_rst", rd, 32'h0);
		wb(1'b0, WDG_ADDR_STATUS, 32'h0);
		chk("status_rst", rd, 32'h0);
		wb(1'b1, WDG_ADDR_ACTION, 32'h0000_2335);
		wb(1'b1, WDG_ADDR_CLOCK, 32'h0000_36bc);
		wb(1'b0, WDG_ADDR_ACTION, 32'h0);
		chk("action_badkey", rd, 32'h0);
		wb(1'b0, WDG_ADDR_CLOCK, 32'h0);
		chk("clock_badkey", rd, 32'h0);
	endtask

	task automatic t_sequence;
		wb(1'b1, WDG_ADDR_ACTION, 32'h0000_2340);
		wb(1'b0, WDG_ADDR_ACTION, 32'h0);
		chk("action_off", rd, 32'h0);
		wb(1'b1, WDG_ADDR_CLOCK, 32'h0000_373c);
		wb(1'b0, WDG_ADDR_CLOCK, 32'h0);
		chk("clock_seq", rd, 32'h0000_003c);
		wb(1'b1, WDG_ADDR_RESTART, 32'h0000_c071);
		wb(1'b1, WDG_ADDR_ACTION, 32'h0000_2345);
		wb(1'b0, WDG_ADDR_ACTION, 32'h0);
		chk("action_on", rd, 32'h0000_0005);
	endtask

	// Preload 0 and divide by 8 keep the timeout near 0x8000 cycles
	task automatic t_overflow;
		wb(1'b1, WDG_ADDR_ACTION, 32'h0000_2340);
		wb(1'b1, WDG_ADDR_CLOCK, 32'h0000_3700);
		wb(1'b1, WDG_ADDR_RESTART, 32'h0000_c071);
		wb(1'b1, WDG_ADDR_ACTION, 32'h0000_234f);
		n = 0;
		while (wd_irq_o !== 1'b1 && n < 40000) begin
			@(posedge clk_i);
			n++;
		end
		chk("timeout_window", 32'((n > 32752) && (n < 32784)), 32'h1);
		chk("reset_level", 32'(wd_reset_o), 32'h1);
		chk("pin_at_irq", 32'(overflow_out_n_o), 32'h0);
		@(posedge clk_i);
		chk("irq_width", 32'(wd_irq_o), 32'h0);
		n = 1;
		while (overflow_out_n_o === 1'b0 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		chk("pin_low_cycles", 32'(n), 32'(WDG_PIN_CYCLES));
		wb(1'b0, WDG_ADDR_STATUS, 32'h0);
		chk("flag_set", rd, 32'h1);
		wb(1'b1, WDG_ADDR_RESTART, 32'h0000_c070);
		wb(1'b0, WDG_ADDR_STATUS, 32'h0);
		chk("flag_badkey", rd, 32'h1);
		wb(1'b1, WDG_ADDR_RESTART, 32'h0000_c071);
		wb(1'b0, WDG_ADDR_STATUS, 32'h0);
		chk("flag_restart", rd, 32'h0);
	endtask

	// Disabled watchdog must stay silent past a full timeout
	task automatic t_disabled;
		wb(1'b1, WDG_ADDR_ACTION, 32'h0000_234e);
		wb(1'b1, WDG_ADDR_RESTART, 32'h0000_c071);
		n = 0;
		while (wd_irq_o !== 1'b1 && overflow_out_n_o !== 1'b0 && n < 34000) begin
			@(posedge clk_i);
			n++;
		end
		chk("disabled_quiet", 32'(n), 32'd34000);
		@(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("reset_cleared", 32'(wd_reset_o), 32'h0);
		wb(1'b0, WDG_ADDR_ACTION, 32'h0);
		chk("action_after_reset", rd, 32'h0);
		wb(1'b0, WDG_ADDR_STATUS, 32'h0);
		chk("status_after_reset", rd, 32'h0);
	endtask

	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset_and_keys();
		t_sequence();
		t_overflow();
		t_disabled();
		tally_and_finish();
	end

	initial begin
		#800000;
		failures++;
		tally_and_finish();
	end
endmodule
